// ==== adc_control.v ====
// control logic of an eight channel eight bit approximation converter
//
// Behaviour
// - exactly one of eight analog inputs is switched on, from the decoded address
// - address pins are binary, third bit most significant, channel 0 to 7
// - address is captured on the strobe rising edge or a soft load and held until the next
// - a start rising edge clears the result output latch
// - sampling begins at the start edge and lasts 32 conversion clock periods
// - a start within the 64 periods aborts and restarts; old result lost
// - done falls within eight clock periods plus two microseconds of start
// - bits are resolved from weight 128 down to weight 1
// - node above trip point records a one and releases that weight
// - node below trip point keeps that weight applied for remaining trials
// - all eight bits are decided in order, most significant first
// - after the eighth bit the sample then convert cycle repeats when auto repeat is set, else it idles
// - result is straight binary, zeros at zero input, ones at full scale
`include "adc_ctrl_consts.vh"
`default_nettype none

module adc_control #(
  parameter CONV_DIV = `CONV_DIV
) (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  // microprocessor side pins
  input  wire [2:0]  chan_addr_in,
  input  wire        addr_strobe_in,
  input  wire        start_in,
  // threshold detector: summing node above trip point
  input  wire        node_above_in,
  // analog switch controls
  output reg  [7:0]  chan_select_out,
  output reg         sampling_out,
  output reg  [7:0]  weight_apply_out,
  // result latch and completion
  output reg  [7:0]  result_out,
  output reg         conv_done_out,
  output reg         irq_out,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out
);

  localparam ST_IDLE    = 2'b00;
  localparam ST_SAMPLE  = 2'b01;
  localparam ST_CONVERT = 2'b10;

  // counts are worked out at full width, then cut to the counter width
  localparam [31:0] SAMPLE_LAST_W = `SAMPLE_PERIODS - 1;
  localparam [31:0] BIT_LAST_W    = `BIT_PERIODS - 1;
  localparam [5:0]  SAMPLE_LAST   = SAMPLE_LAST_W[5:0];
  localparam [5:0]  BIT_LAST      = BIT_LAST_W[5:0];

  // ==========================================================
  // functions
  function [7:0] one_hot;
    input [2:0] idx;
    begin
      one_hot = 8'h01 << idx;
    end
  endfunction

  function addr_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      addr_hit = (addr == off);
    end
  endfunction

  // ==========================================================
  // state
  reg [1:0]  state;
  reg [5:0]  period_cnt;
  reg [2:0]  bit_idx;
  reg [7:0]  approximation_register;
  reg [2:0]  chan_code;
  reg        strobe_prev;
  reg        start_prev;
  reg        auto_repeat;
  reg        soft_start;
  reg        soft_load;
  reg [1:0]  int_status;
  reg [1:0]  int_mask;
  reg        done_event;
  reg        abort_event;

  wire       tick;
  wire       apb_done   = psel_in & penable_in & pready_out;
  wire       apb_write  = apb_done & pwrite_in;
  wire       lane0      = pstrb_in[0];
  wire       strobe_rise = addr_strobe_in & ~strobe_prev;
  wire       start_rise  = (start_in & ~start_prev) | soft_start;
  wire       busy        = (state != ST_IDLE);
  wire       mapped      = addr_hit(paddr_in, `REG_CTRL_OFF)
                         | addr_hit(paddr_in, `REG_STATUS_OFF)
                         | addr_hit(paddr_in, `REG_RESULT_OFF)
                         | addr_hit(paddr_in, `REG_INT_STATUS_OFF)
                         | addr_hit(paddr_in, `REG_INT_MASK_OFF);
  wire [7:0] decided     = approximation_register |
                           (node_above_in ? one_hot(bit_idx) : 8'h00);

  // ==========================================================
  // conversion clock
  conv_tick_gen #(
    .DIV (CONV_DIV)
  ) conv_tick_gen_i (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .restart_in  (start_rise),
    .tick_out    (tick)
  );

  // ==========================================================
  // edge detection of the synchronous pins
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strobe_prev <= 1'b0;
      start_prev  <= 1'b0;
    end else begin
      strobe_prev <= addr_strobe_in;
      start_prev  <= start_in;
    end
  end

  // ==========================================================
  // address latch and multiplexer decode
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chan_code       <= `CHAN_RESET;
      chan_select_out <= 8'h01;
    end else if (strobe_rise || soft_load) begin
      // soft load reuses the pins so a bus-only host can pick a channel
      chan_code       <= chan_addr_in;
      chan_select_out <= one_hot(chan_addr_in);
    end
  end

  // ==========================================================
  // sequencer
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state                  <= ST_IDLE;
      period_cnt             <= 6'h00;
      bit_idx                <= 3'h7;
      approximation_register <= 8'h00;
      weight_apply_out       <= 8'h00;
      sampling_out           <= 1'b0;
      result_out             <= `RESULT_RESET;
      conv_done_out          <= 1'b0;
      done_event             <= 1'b0;
      abort_event            <= 1'b0;
    end else begin
      done_event  <= 1'b0;
      abort_event <= 1'b0;
      if (start_rise) begin
        // any start restarts, the running result is thrown away
        abort_event            <= busy;
        result_out             <= `RESULT_RESET;
        conv_done_out          <= 1'b0;
        state                  <= ST_SAMPLE;
        sampling_out           <= 1'b1;
        period_cnt             <= 6'h00;
        approximation_register <= 8'h00;
        weight_apply_out       <= 8'h00;
        bit_idx                <= 3'h7;
      end else if (tick) begin
        case (state)
          ST_SAMPLE: begin
            if (period_cnt == SAMPLE_LAST) begin
              state            <= ST_CONVERT;
              sampling_out     <= 1'b0;
              period_cnt       <= 6'h00;
              bit_idx          <= 3'h7;
              weight_apply_out <= one_hot(3'h7);
            end else begin
              period_cnt <= period_cnt + 6'h01;
            end
          end
          ST_CONVERT: begin
            if (period_cnt == BIT_LAST) begin
              period_cnt <= 6'h00;
              // trial ends: above sets the bit and drops the weight
              if (node_above_in) begin
                approximation_register <= decided;
                weight_apply_out       <= weight_apply_out & ~one_hot(bit_idx);
              end
              // below leaves the weight in place to the end
              if (bit_idx == 3'h0) begin
                result_out    <= decided;
                conv_done_out <= 1'b1;
                done_event    <= 1'b1;
                if (auto_repeat) begin
                  // latch and done hold while the next sample runs
                  state            <= ST_SAMPLE;
                  sampling_out     <= 1'b1;
                  weight_apply_out <= 8'h00;
                  approximation_register <= 8'h00;
                end else begin
                  state            <= ST_IDLE;
                  weight_apply_out <= 8'h00;
                end
              end else begin
                bit_idx          <= bit_idx - 3'h1;
                weight_apply_out <= (node_above_in ?
                                     (weight_apply_out & ~one_hot(bit_idx)) :
                                     weight_apply_out)
                                    | one_hot(bit_idx - 3'h1);
              end
            end else begin
              period_cnt <= period_cnt + 6'h01;
            end
          end
          ST_IDLE: begin
            sampling_out <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // control register and interrupts
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      auto_repeat <= `CTRL_RESET;
      soft_start  <= 1'b0;
      soft_load   <= 1'b0;
      int_status  <= 2'h0;
      int_mask    <= `INT_MASK_RESET;
      irq_out     <= 1'b0;
    end else begin
      soft_start <= 1'b0;
      soft_load  <= 1'b0;
      if (apb_write && lane0 && addr_hit(paddr_in, `REG_CTRL_OFF)) begin
        auto_repeat <= pwdata_in[`CTRL_AUTO_REPEAT_BIT];
        soft_start  <= pwdata_in[`CTRL_SOFT_START_BIT];
        soft_load   <= pwdata_in[`CTRL_SOFT_LOAD_BIT];
      end
      if (apb_write && lane0 && addr_hit(paddr_in, `REG_INT_MASK_OFF)) begin
        int_mask <= pwdata_in[1:0];
      end
      // a new event beats a clear in the same cycle
      if (apb_write && lane0 && addr_hit(paddr_in, `REG_INT_STATUS_OFF)) begin
        int_status <= (int_status & ~pwdata_in[1:0]) | {abort_event, done_event};
      end else begin
        int_status <= int_status | {abort_event, done_event};
      end
      // one cycle behind the status bits, kept registered
      irq_out <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // apb slave, one wait state on every access
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
      prdata_out  <= 32'h00000000;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        if (addr_hit(paddr_in, `REG_CTRL_OFF)) begin
          prdata_out[`CTRL_AUTO_REPEAT_BIT] <= auto_repeat;
        end
        if (addr_hit(paddr_in, `REG_STATUS_OFF)) begin
          prdata_out[`STAT_BUSY_BIT]     <= busy;
          prdata_out[`STAT_DONE_BIT]     <= conv_done_out;
          prdata_out[`STAT_SAMPLING_BIT] <= sampling_out;
          prdata_out[`STAT_CHAN_LSB+2:`STAT_CHAN_LSB] <= chan_code;
        end
        if (addr_hit(paddr_in, `REG_RESULT_OFF)) begin
          prdata_out[7:0] <= result_out;
        end
        if (addr_hit(paddr_in, `REG_INT_STATUS_OFF)) begin
          prdata_out[1:0] <= int_status;
        end
        if (addr_hit(paddr_in, `REG_INT_MASK_OFF)) begin
          prdata_out[1:0] <= int_mask;
        end
      end
    end
  end

endmodule // adc_control

`default_nettype wire

// ==== adc_control_props.sv ====
// concurrent checks on the ports of the converter control block
`default_nettype none
module adc_control_props #(parameter int CONV_DIV = 4) (
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic [2:0] chan_addr_in,
  input wire logic       addr_strobe_in,
  input wire logic       start_in,
  input wire logic       node_above_in,
  input wire logic [7:0] chan_select_out,
  input wire logic       sampling_out,
  input wire logic [7:0] weight_apply_out,
  input wire logic [7:0] result_out,
  input wire logic       conv_done_out,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       pready_out,
  input wire logic       pslverr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // helpers
  localparam int SAMP = 32 * CONV_DIV;
  logic [15:0] samp_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  function automatic logic [7:0] low_bit(input logic [7:0] w);
    return w & (~w + 8'h01);
  endfunction
  // restarted by a start edge since an abort resamples
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) samp_cnt <= 16'h0000;
    else if (!sampling_out || $rose(start_in)) samp_cnt <= 16'h0000;
    else samp_cnt <= samp_cnt + 16'h0001;
  end
  sequence start_edge;
    $rose(start_in);
  endsequence
  sequence trial_end;
    $changed(weight_apply_out) && $past(weight_apply_out) != 8'h00 && weight_apply_out != 8'h00;
  endsequence
  // ==========================================
  // assertions
  one_channel_a: assert property ($onehot(chan_select_out))
    else $error("channel select not one-hot");
  addr_load_a: assert property ($rose(addr_strobe_in) |=>
    chan_select_out == (8'h01 << $past(chan_addr_in))) else $error("channel load wrong");
  start_clear_a: assert property (start_edge |=> result_out == 8'h00 && sampling_out)
    else $error("start did not clear result");
  sample_len_a: assert property ($fell(sampling_out) |->
    samp_cnt >= SAMP - 4 && samp_cnt <= SAMP + CONV_DIV + 4) else $error("sample span wrong");
  done_drop_a: assert property (start_edge |-> ##[1:8] !conv_done_out)
    else $error("done did not drop");
  msb_first_a: assert property ($fell(sampling_out) |-> weight_apply_out == 8'h80)
    else $error("first trial not msb");
  trial_step_a: assert property (trial_end |-> weight_apply_out ==
    (($past(weight_apply_out) & ~(low_bit($past(weight_apply_out)) & {8{$past(node_above_in)}}))
    | (low_bit($past(weight_apply_out)) >> 1))) else $error("bit trial step wrong");
  done_result_a: assert property ($rose(conv_done_out) |-> weight_apply_out == 8'h00 &&
    result_out == ((~$past(weight_apply_out) & 8'hFE) | {7'h00, $past(node_above_in)}))
    else $error("done without matching result");
  wait_state_a: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("apb wait state wrong");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule // adc_control_props

bind adc_control adc_control_props #(.CONV_DIV(CONV_DIV)) props_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .chan_addr_in(chan_addr_in),
  .addr_strobe_in(addr_strobe_in), .start_in(start_in), .node_above_in(node_above_in),
  .chan_select_out(chan_select_out), .sampling_out(sampling_out),
  .weight_apply_out(weight_apply_out), .result_out(result_out), .conv_done_out(conv_done_out),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// ==== adc_ctrl_consts.vh ====
// constants of the eight channel converter control block
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// ==========================================================
// register byte offsets
`define REG_CTRL_OFF        12'h000
`define REG_STATUS_OFF      12'h004
`define REG_RESULT_OFF      12'h008
`define REG_INT_STATUS_OFF  12'h00C
`define REG_INT_MASK_OFF    12'h010

// ==========================================================
// field positions
`define CTRL_AUTO_REPEAT_BIT  0
`define CTRL_SOFT_START_BIT   1
`define CTRL_SOFT_LOAD_BIT    2
`define STAT_BUSY_BIT         0
`define STAT_DONE_BIT         1
`define STAT_SAMPLING_BIT     2
`define STAT_CHAN_LSB         4
`define INT_DONE_BIT          0
`define INT_ABORT_BIT         1

// ==========================================================
// reset values
`define CTRL_RESET        1'b0
`define INT_MASK_RESET    2'h0
`define CHAN_RESET        3'h0
`define RESULT_RESET      8'h00

// ==========================================================
// timing, in conversion clock periods and clock rates
`define SAMPLE_PERIODS    32
`define CONVERT_PERIODS   64
`define RESULT_BITS       8
`define BIT_PERIODS       ((`CONVERT_PERIODS - `SAMPLE_PERIODS) / `RESULT_BITS)
`define CORE_CLK_KHZ      100000
`define CONV_CLK_KHZ      640
`define CONV_DIV          (`CORE_CLK_KHZ / `CONV_CLK_KHZ)

`endif

// ==== conv_tick_gen.v ====
// divider that makes the conversion clock tick from the core clock
`default_nettype none

module conv_tick_gen #(
  parameter DIV = 156
) (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire        restart_in,
  output reg         tick_out
);

  // full width copy so the compare slice below is taken on purpose
  localparam [31:0] DIV_W = DIV;

  reg [15:0] count;

  // ==========================================================
  // divider, realigned on restart so sampling spans whole periods
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count    <= 16'h0000;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      count    <= 16'h0000;
      tick_out <= 1'b0;
    end else if (count == DIV_W[15:0] - 16'h0001) begin
      count    <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 16'h0001;
      tick_out <= 1'b0;
    end
  end

endmodule // conv_tick_gen

`default_nettype wire

// ==== node_model.sv ====
// threshold detector model fed by a level per channel
`default_nettype none
module node_model (
  input  wire logic [7:0]  chan_select_in,
  input  wire logic [7:0]  weight_apply_in,
  input  wire logic [63:0] levels_in,
  output logic             node_above_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] trial;
  logic [7:0] level;
  logic [7:0] code;
  // decided ones are the released weights above the newest trial bit
  always_comb begin
    level = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (chan_select_in[i]) level = levels_in[8*i +: 8];
    end
    trial = weight_apply_in & (~weight_apply_in + 8'h01);
    code = (~weight_apply_in & ~((trial << 1) - 8'h01)) | trial;
    node_above_out = (code <= level);
  end
endmodule // node_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the converter control block
`include "adc_ctrl_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, rstn_in, addr_strobe_in, start_in, psel_in, penable_in, pwrite_in, node;
  logic [2:0] chan_addr_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata, rd;
  logic [3:0] pstrb_in;
  logic [7:0] sel, wgt, res;
  logic samp, done, irq, pready, perr, err, loop_on;
  logic [63:0] levels;
  int fail_count, checks_done;
  adc_control #(.CONV_DIV(4)) adc_control_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .chan_addr_in(chan_addr_in), .addr_strobe_in(addr_strobe_in), .start_in(start_in),
    .node_above_in(node), .chan_select_out(sel), .sampling_out(samp), .weight_apply_out(wgt),
    .result_out(res), .conv_done_out(done), .irq_out(irq), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr));
  node_model node_model_i (.chan_select_in(sel), .weight_apply_in(wgt), .levels_in(levels),
    .node_above_out(node));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // host wiring of done back to start for the continuous loop
  always @(posedge core_clk_in) begin
    if (loop_on) start_in <= done;
  end
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // values are read before the edge's own updates land, as a sampled bus
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1 && ++n < 20);
    check("pready", pready, 1'b1);
    rd = prdata;
    err = perr;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(posedge core_clk_in);
      n++;
    end
    @(posedge core_clk_in);
    check("done", done, 1'b1);
  endtask
  task automatic conv(input int c);
    start_in <= 1'b1;
    @(posedge core_clk_in);
    start_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    check("result cleared", res, 8'h00);
    check("done low", done, 1'b0);
    check("sampling", samp, 1'b1);
    if (c >= 0) begin
      wait_done();
      check("result", res, levels[8*c +: 8]);
    end
  endtask
  // ==========================================
  // tests
  initial begin
    {rstn_in, addr_strobe_in, start_in, psel_in, penable_in, pwrite_in, loop_on} = 7'h00;
    {chan_addr_in, paddr_in, pwdata_in} = 47'h0;
    pstrb_in = 4'hF;
    levels = 64'hFF5A01803CA57F00;
    repeat (2) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    check("reset select", sel, 8'h01);
    check("reset done", done, 1'b0);
    for (int c = 0; c < 8; c++) begin
      chan_addr_in <= c[2:0];
      addr_strobe_in <= 1'b1;
      @(posedge core_clk_in);
      addr_strobe_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      check("select", sel, 8'h01 << c);
      chan_addr_in <= 3'h2;
      repeat (2) @(posedge core_clk_in);
      check("select held", sel, 8'h01 << c);
      conv(c);
    end
    addr_strobe_in <= 1'b1;
    conv(-1);
    addr_strobe_in <= 1'b0;
    check("irq masked", irq, 1'b0);
    apb(1'b1, `REG_INT_MASK_OFF, 32'h3);
    repeat (200) @(posedge core_clk_in);
    conv(2);
    apb(1'b0, `REG_INT_STATUS_OFF, 32'h0);
    check("int status", rd, 32'h3);
    check("irq", irq, 1'b1);
    pstrb_in <= 4'h0;
    apb(1'b1, `REG_INT_MASK_OFF, 32'h0);
    pstrb_in <= 4'hF;
    apb(1'b0, `REG_INT_MASK_OFF, 32'h0);
    check("mask kept", rd, 32'h3);
    apb(1'b1, `REG_INT_STATUS_OFF, 32'h3);
    apb(1'b0, `REG_STATUS_OFF, 32'h0);
    check("status chan", rd[6:4], 3'h2);
    check("status flags", rd[3:0], 4'h2);
    check("irq cleared", irq, 1'b0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `REG_CTRL_OFF, 32'h3);
    repeat (3) @(posedge core_clk_in);
    wait_done();
    levels[23:16] = 8'h42;
    for (int n = 0; n < 700 && res !== 8'h42; n++) @(posedge core_clk_in);
    check("repeat result", res, 8'h42);
    check("repeat done", done, 1'b1);
    apb(1'b0, `REG_CTRL_OFF, 32'h0);
    check("ctrl read", rd, 32'h1);
    apb(1'b0, `REG_RESULT_OFF, 32'h0);
    check("result reg", rd, 32'h42);
    // ==========================================
    // reset in mid-run, then the done to start loop
    rstn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    check("mid reset done", done, 1'b0);
    check("mid reset result", res, 8'h00);
    check("mid reset select", sel, 8'h01);
    chan_addr_in <= 3'h5;
    apb(1'b1, `REG_CTRL_OFF, 32'h4);
    apb(1'b0, `REG_STATUS_OFF, 32'h0);
    check("soft load chan", rd[6:4], 3'h5);
    check("soft load select", sel, 8'h20);
    // the loop cannot begin by itself while done is low
    loop_on <= 1'b1;
    repeat (20) @(posedge core_clk_in);
    check("no self start", samp, 1'b0);
    loop_on <= 1'b0;
    @(posedge core_clk_in);
    start_in <= 1'b1;
    @(posedge core_clk_in);
    loop_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_done();
      check("loop result", res, levels[47:40]);
      repeat (2) @(posedge core_clk_in);
    end
    stop_test();
  end
  initial begin
    repeat (10000) @(posedge core_clk_in);
    fail_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
